/* File: logic/iflg_ctrl.sv */
// Chosen here: the address map and the plain strobed port.
module iflg_ctrl
    import iflg_pkg::*;
#(
    parameter int PC_W = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // external pins, asynchronous
    input wire logic [7:0] i_wakeup_pin_n,
    input wire logic [4:0] i_req_pin,
    input wire logic i_capture_input_pin,
    // peripheral events and state, system clock
    input wire logic i_timer_a_ovf,
    input wire logic i_serial_done,
    input wire logic i_xfer_done,
    input wire logic i_conv_start_flag,
    input wire logic i_capture_pin_en,
    input wire logic i_capture_rise,
    input wire logic i_capture_ovf_en,
    input wire logic [7:0] i_capture_counter,
    input wire logic i_cmp_16bit_mode,
    input wire logic [7:0] i_compare_counter_low,
    input wire logic [7:0] i_compare_counter_high,
    input wire logic [7:0] i_compare_value_low,
    input wire logic [7:0] i_compare_value_high,
    input wire logic [15:0] i_ovf_counter,
    // cpu core
    input wire logic i_insn_done,
    input wire logic [PC_W-1:0] i_next_pc,
    input wire logic [7:0] i_ccr,
    input wire logic i_vec_valid,
    input wire logic [PC_W-1:0] i_vec_data,
    output logic o_irq_pending,
    output logic o_stack_push,
    output logic [PC_W-1:0] o_stack_pc,
    output logic [7:0] o_stack_ccr,
    output logic o_vec_rd,
    output logic [PC_W-1:0] o_vec_addr,
    output logic o_jump,
    output logic [PC_W-1:0] o_jump_pc,
    output logic o_mask
);
    // ************************************************************
    // parameter check
    // ************************************************************
    if (PC_W < 6 || PC_W > 32) begin : g_bad_pc_w
        $error("iflg_ctrl: PC_W must be 6 to 32");
    end

    typedef struct packed {
        logic [7:0] wake_s1;
        logic [7:0] wake_s2;
        logic [7:0] wake_prev;
        logic [4:0] req_s1;
        logic [4:0] req_s2;
        logic [4:0] req_prev;
        logic cap_s1;
        logic cap_s2;
        logic cap_prev;
        logic conv_prev;
        logic [7:0] cap_cnt_prev;
        logic [15:0] ovf_cnt_prev;
        logic hi_match_prev;
        logic lo_match_prev;
        logic [7:0] req_one;
        logic [7:0] req_two;
        logic [7:0] wake_flags;
        logic [7:0] en_one;
        logic [7:0] en_two;
        logic [4:0] edge_sel;
        logic [7:0] wake_func;
        logic [4:0] req_func;
        logic mask;
        logic [4:0] vec;
        logic [4:0] last_vec;
        iflg_state_e st;
        logic [PC_W-1:0] pc;
        logic [7:0] condition_code_register;
        logic [PC_W-1:0] target;
        logic [7:0] rdata;
    } iflg_regs_s;

    localparam iflg_regs_s REGS_RST = '{
        wake_s1: 8'hFF, wake_s2: 8'hFF, wake_prev: 8'hFF,
        req_s1: 5'h00, req_s2: 5'h00, req_prev: 5'h00,
        cap_s1: 1'b0, cap_s2: 1'b0, cap_prev: 1'b0, conv_prev: 1'b0,
        cap_cnt_prev: 8'h00, ovf_cnt_prev: 16'h0000,
        hi_match_prev: 1'b0, lo_match_prev: 1'b0,
        req_one: RST_REQ_ONE, req_two: RST_REQ_TWO, wake_flags: RST_ZERO,
        en_one: RST_ZERO, en_two: RST_EN_TWO, edge_sel: 5'h00,
        wake_func: RST_ZERO, req_func: 5'h00, mask: RST_MASK,
        vec: 5'h00, last_vec: 5'h00, st: ST_IDLE,
        pc: '0, condition_code_register: 8'h00, target: '0, rdata: 8'h00
    };

    iflg_regs_s r;
    iflg_regs_s next_r;

    // ************************************************************
    // helpers
    // ************************************************************
    // lowest set index wins: the printed priority table is not at hand
    function automatic logic [4:0] lowest_vec(input logic [NUM_VEC-1:0] req);
        logic [4:0] v;
        v = 5'h00;
        for (int i = NUM_VEC - 1; i >= 0; i--) begin
            if (req[i]) begin
                v = 5'(i);
            end
        end
        return v;
    endfunction

    // write-zero clear: a written 1 leaves the flag alone
    function automatic logic [7:0] zero_clear(input logic [7:0] flags, input logic [7:0] wd,
                                              input logic hit);
        return hit ? (flags & wd) : flags;
    endfunction

    // ************************************************************
    // event detection
    // ************************************************************
    logic [7:0] wake_fall;
    logic [4:0] req_edge;
    logic cap_edge;
    logic cap_wrap;
    logic conv_end;
    logic hi_match;
    logic lo_match;
    logic ovf_wrap;
    logic [NUM_VEC-1:0] pend;

    always_comb begin
        wake_fall = r.wake_func & r.wake_prev & ~r.wake_s2;
        conv_end = r.conv_prev & ~i_conv_start_flag;
        cap_edge = i_capture_pin_en &&
                   (i_capture_rise ? (r.cap_s2 && !r.cap_prev)
                                   : (!r.cap_s2 && r.cap_prev));
        cap_wrap = i_capture_ovf_en && r.cap_cnt_prev == CAP_TOP
                   && i_capture_counter == CAP_BOTTOM;
        hi_match = i_cmp_16bit_mode
                   ? ({i_compare_counter_high, i_compare_counter_low}
                      == {i_compare_value_high, i_compare_value_low})
                   : (i_compare_counter_high == i_compare_value_high);
        lo_match = !i_cmp_16bit_mode
                   && i_compare_counter_low == i_compare_value_low;
        ovf_wrap = r.ovf_cnt_prev == OVF_TOP && i_ovf_counter == OVF_BOTTOM;
    end

    for (genvar n = 0; n < 5; n++) begin : g_req_edge
        // edge select bit 1 picks rising, 0 picks falling
        assign req_edge[n] = r.req_func[n] &&
                             (r.edge_sel[n] ? (r.req_s2[n] && !r.req_prev[n])
                                            : (!r.req_s2[n] && r.req_prev[n]));
    end

    // ************************************************************
    // pending requests by vector number
    // ************************************************************
    always_comb begin
        pend = '0;
        for (int n = 0; n < 5; n++) begin
            pend[VEC_REQ_PIN0 + 5'(n)] = r.req_one[n] & r.en_one[n];
        end
        pend[VEC_WAKE] = (|r.wake_flags) & r.en_one[E1_WAKE_EN];
        pend[VEC_TIMER_A] = r.req_one[B1_TIMER_A] & r.en_one[B1_TIMER_A];
        pend[VEC_SERIAL] = r.req_one[B1_SERIAL] & r.en_one[B1_SERIAL];
        pend[VEC_XFER] = r.req_two[B2_XFER] & r.en_two[B2_XFER];
        pend[VEC_CAPTURE] = r.req_two[B2_CAPTURE] & r.en_two[B2_CAPTURE];
        pend[VEC_CMP_LOW] = r.req_two[B2_CMP_LOW] & r.en_two[B2_CMP_LOW];
        pend[VEC_CMP_HIGH] = r.req_two[B2_CMP_HIGH] & r.en_two[B2_CMP_HIGH];
        pend[VEC_OVF] = r.req_two[B2_OVF] & r.en_two[B2_OVF];
        pend[VEC_CONV] = r.req_two[B2_CONV] & r.en_two[B2_CONV];
    end

    // ************************************************************
    // next state
    // ************************************************************
    logic wr_one;
    logic wr_two;
    logic wr_wake;

    always_comb begin
        next_r = r;
        wr_one = i_wr && i_addr == OFS_REQ_ONE;
        wr_two = i_wr && i_addr == OFS_REQ_TWO;
        wr_wake = i_wr && i_addr == OFS_WAKE_FLAGS;

        // synchronisers and previous samples
        next_r.wake_s1 = i_wakeup_pin_n;
        next_r.wake_s2 = r.wake_s1;
        next_r.wake_prev = r.wake_s2;
        next_r.req_s1 = i_req_pin;
        next_r.req_s2 = r.req_s1;
        next_r.req_prev = r.req_s2;
        next_r.cap_s1 = i_capture_input_pin;
        next_r.cap_s2 = r.cap_s1;
        next_r.cap_prev = r.cap_s2;
        next_r.conv_prev = i_conv_start_flag;
        next_r.cap_cnt_prev = i_capture_counter;
        next_r.ovf_cnt_prev = i_ovf_counter;
        next_r.hi_match_prev = hi_match;
        next_r.lo_match_prev = lo_match;

        // flags: clear first, then events set, so a set wins
        next_r.req_one = zero_clear(r.req_one, i_wdata, wr_one);
        next_r.req_one[B1_RESERVED] = 1'b1;
        next_r.req_one[4:0] = next_r.req_one[4:0] | req_edge;
        if (i_timer_a_ovf) begin
            next_r.req_one[B1_TIMER_A] = 1'b1;
        end
        if (i_serial_done) begin
            next_r.req_one[B1_SERIAL] = 1'b1;
        end

        next_r.req_two = zero_clear(r.req_two, i_wdata, wr_two);
        // overflow flag ignores its own bit, follows the clear bit
        next_r.req_two[B2_OVF] = r.req_two[B2_OVF]
                                 && !(wr_two && !i_wdata[B2_OVF_CLR]);
        next_r.req_two[B2_OVF_CLR] = 1'b1;
        next_r.req_two[B2_RESERVED] = 1'b0;
        if (i_xfer_done) begin
            next_r.req_two[B2_XFER] = 1'b1;
        end
        if (conv_end) begin
            next_r.req_two[B2_CONV] = 1'b1;
        end
        if (cap_edge || cap_wrap) begin
            next_r.req_two[B2_CAPTURE] = 1'b1;
        end
        if (hi_match && !r.hi_match_prev) begin
            next_r.req_two[B2_CMP_HIGH] = 1'b1;
        end
        if (lo_match && !r.lo_match_prev) begin
            next_r.req_two[B2_CMP_LOW] = 1'b1;
        end
        if (ovf_wrap) begin
            next_r.req_two[B2_OVF] = 1'b1;
        end

        next_r.wake_flags = zero_clear(r.wake_flags, i_wdata, wr_wake)
                            | wake_fall;

        // plain control registers
        if (i_wr) begin
            case (i_addr)
                OFS_EN_ONE: begin
                    next_r.en_one = i_wdata;
                end
                OFS_EN_TWO: begin
                    next_r.en_two = i_wdata;
                    next_r.en_two[B2_RESERVED] = 1'b0;
                    next_r.en_two[B2_OVF_CLR] = 1'b1;
                end
                OFS_EDGE_SEL: begin
                    next_r.edge_sel = i_wdata[4:0];
                end
                OFS_WAKE_FUNC: begin
                    next_r.wake_func = i_wdata;
                end
                OFS_REQ_FUNC: begin
                    next_r.req_func = i_wdata[4:0];
                end
                OFS_MASK: begin
                    next_r.mask = i_wdata[0];
                end
                default: begin
                end
            endcase
        end

        // acceptance sequence
        case (r.st)
            ST_IDLE: begin
                if (!r.mask && |pend) begin
                    next_r.vec = lowest_vec(pend);
                    next_r.mask = 1'b1;
                    next_r.st = ST_WAIT_INSN;
                end
            end
            ST_WAIT_INSN: begin
                if (i_insn_done) begin
                    next_r.pc = i_next_pc;
                    next_r.condition_code_register = i_ccr & ~(8'h01 << CCR_MASK_BIT);
                    next_r.st = ST_PUSH;
                end
            end
            ST_PUSH: begin
                next_r.st = ST_FETCH;
            end
            ST_FETCH: begin
                next_r.st = ST_WAIT_VEC;
            end
            ST_WAIT_VEC: begin
                if (i_vec_valid) begin
                    next_r.target = i_vec_data;
                    next_r.last_vec = r.vec;
                    next_r.st = ST_JUMP;
                end
            end
            ST_JUMP: begin
                next_r.st = ST_IDLE;
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase

        // read port, data one cycle later
        next_r.rdata = 8'h00;
        if (i_rd) begin
            case (i_addr)
                OFS_REQ_ONE: next_r.rdata = r.req_one;
                OFS_REQ_TWO: next_r.rdata = r.req_two;
                OFS_WAKE_FLAGS: next_r.rdata = r.wake_flags;
                OFS_EN_ONE: next_r.rdata = r.en_one;
                OFS_EN_TWO: next_r.rdata = r.en_two;
                OFS_EDGE_SEL: next_r.rdata = {3'h0, r.edge_sel};
                OFS_WAKE_FUNC: next_r.rdata = r.wake_func;
                OFS_REQ_FUNC: next_r.rdata = {3'h0, r.req_func};
                OFS_MASK: next_r.rdata = {7'h00, r.mask};
                OFS_LAST_VEC: next_r.rdata = {3'h0, r.last_vec};
                default: next_r.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            r <= REGS_RST;
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_rdata = r.rdata;
    assign o_irq_pending = |pend;
    assign o_stack_push = r.st == ST_PUSH;
    assign o_stack_pc = r.pc;
    assign o_stack_ccr = r.condition_code_register;
    assign o_vec_rd = r.st == ST_FETCH;
    // word vectors: address is twice the vector number
    assign o_vec_addr = PC_W'({r.vec, 1'b0});
    assign o_jump = r.st == ST_JUMP;
    assign o_jump_pc = r.target;
    assign o_mask = r.mask;
endmodule

/* File: logic/iflg_pkg.sv */
package iflg_pkg;
    // ************************************************************
    // register map (byte-wide registers, 4-bit address)
    // ************************************************************
    localparam logic [3:0] OFS_REQ_ONE = 4'h0;
    localparam logic [3:0] OFS_REQ_TWO = 4'h1;
    localparam logic [3:0] OFS_WAKE_FLAGS = 4'h2;
    localparam logic [3:0] OFS_EN_ONE = 4'h3;
    localparam logic [3:0] OFS_EN_TWO = 4'h4;
    localparam logic [3:0] OFS_EDGE_SEL = 4'h5;
    localparam logic [3:0] OFS_WAKE_FUNC = 4'h6;
    localparam logic [3:0] OFS_REQ_FUNC = 4'h7;
    localparam logic [3:0] OFS_MASK = 4'h8;
    localparam logic [3:0] OFS_LAST_VEC = 4'h9;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int B1_TIMER_A = 7;
    localparam int B1_SERIAL = 6;
    localparam int B1_RESERVED = 5;
    localparam int B2_XFER = 7;
    localparam int B2_CONV = 6;
    localparam int B2_RESERVED = 5;
    localparam int B2_CAPTURE = 4;
    localparam int B2_CMP_HIGH = 3;
    localparam int B2_CMP_LOW = 2;
    localparam int B2_OVF = 1;
    localparam int B2_OVF_CLR = 0;
    localparam int E1_WAKE_EN = 5;
    localparam int CCR_MASK_BIT = 7;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [7:0] RST_REQ_ONE = 8'h20;
    localparam logic [7:0] RST_REQ_TWO = 8'h01;
    localparam logic [7:0] RST_EN_TWO = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic RST_MASK = 1'b1;

    // ************************************************************
    // vector numbers
    // ************************************************************
    localparam int NUM_VEC = 21;
    localparam logic [4:0] VEC_REQ_PIN0 = 5'h04;
    localparam logic [4:0] VEC_WAKE = 5'h09;
    localparam logic [4:0] VEC_TIMER_A = 5'h0B;
    localparam logic [4:0] VEC_SERIAL = 5'h0C;
    localparam logic [4:0] VEC_XFER = 5'h0D;
    localparam logic [4:0] VEC_CAPTURE = 5'h0E;
    localparam logic [4:0] VEC_CMP_LOW = 5'h0F;
    localparam logic [4:0] VEC_CMP_HIGH = 5'h10;
    localparam logic [4:0] VEC_OVF = 5'h11;
    localparam logic [4:0] VEC_CONV = 5'h13;

    // ************************************************************
    // counter wrap points
    // ************************************************************
    localparam logic [7:0] CAP_TOP = 8'hFF;
    localparam logic [7:0] CAP_BOTTOM = 8'h00;
    localparam logic [15:0] OVF_TOP = 16'hFFFF;
    localparam logic [15:0] OVF_BOTTOM = 16'h0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_WAIT_INSN = 3'b001,
        ST_PUSH = 3'b010,
        ST_FETCH = 3'b011,
        ST_WAIT_VEC = 3'b100,
        ST_JUMP = 3'b101
    } iflg_state_e;
endpackage

/* File: test/iflg_ctrl_monitor.sv */
module iflg_ctrl_monitor
    import iflg_pkg::*;
#(
    parameter int PC_W = 16
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // register port
    input wire logic [3:0] i_addr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // cpu core
    input wire logic i_insn_done,
    input wire logic [PC_W-1:0] i_next_pc,
    input wire logic [7:0] i_ccr,
    input wire logic i_vec_valid,
    input wire logic [PC_W-1:0] i_vec_data,
    input wire logic o_irq_pending,
    input wire logic o_stack_push,
    input wire logic [PC_W-1:0] o_stack_pc,
    input wire logic [7:0] o_stack_ccr,
    input wire logic o_vec_rd,
    input wire logic [PC_W-1:0] o_vec_addr,
    input wire logic o_jump,
    input wire logic [PC_W-1:0] o_jump_pc,
    input wire logic o_mask
);
    timeunit 1ns;
    timeprecision 100ps;

    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    // ************************************************************
    // register port
    // ************************************************************
    AST_RDATA_IDLE: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside read answer");
    AST_REQ_TWO_FIXED: assert property ($past(i_rd) && $past(i_addr) == OFS_REQ_TWO
        |-> !o_rdata[B2_RESERVED] && o_rdata[B2_OVF_CLR])
        else $error("fixed bits of request register two wrong");

    // ************************************************************
    // acceptance
    // ************************************************************
    AST_MASK_ON_TAKE: assert property (!o_mask && o_irq_pending |=> o_mask)
        else $error("pending request not taken with mask clear");
    AST_PUSH_MASKED: assert property (o_stack_push |-> o_mask)
        else $error("stacking while mask clear");
    AST_PUSH_AFTER_INSN: assert property (o_stack_push |-> $past(i_insn_done))
        else $error("stacking before instruction done");
    AST_PUSH_DATA: assert property (o_stack_push |-> o_stack_pc == $past(i_next_pc)
        && o_stack_ccr == ($past(i_ccr) & 8'h7F))
        else $error("stacked pc or ccr wrong");
    AST_VEC_AFTER_PUSH: assert property (o_stack_push |=> o_vec_rd && !o_vec_addr[0])
        else $error("vector read does not follow stacking");
    AST_VEC_RANGE: assert property (o_vec_rd |-> o_vec_addr >= 8 && o_vec_addr <= 40)
        else $error("vector address out of range");
    AST_JUMP_DATA: assert property (o_jump |-> $past(i_vec_valid)
        && o_jump_pc == $past(i_vec_data))
        else $error("jump without handler word");
    AST_JUMP_PULSE: assert property (o_jump |=> !o_jump [*2])
        else $error("jump pulse too long");
endmodule

/* File: test/iflg_cpu_model.sv */
module iflg_cpu_model (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // pacing
    input wire logic i_slow,
    // controller side
    input wire logic i_vec_rd,
    input wire logic [15:0] i_vec_addr,
    output logic o_insn_done,
    output logic [15:0] o_next_pc,
    output logic [7:0] o_ccr,
    output logic o_vec_valid,
    output logic [15:0] o_vec_data
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [1:0] insn_cnt;
    logic [1:0] vec_cnt;
    logic [15:0] handler;

    assign o_ccr = 8'hA5;
    // stale word inverted so late sampling cannot pass by luck
    assign o_vec_data = o_vec_valid ? handler : ~handler;

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_next_pc <= 16'h0000;
            insn_cnt <= 2'h0;
            vec_cnt <= 2'h0;
            handler <= 16'h0000;
            o_insn_done <= 1'b0;
            o_vec_valid <= 1'b0;
        end else begin
            o_next_pc <= o_next_pc + 16'h0002;
            insn_cnt <= insn_cnt + 2'h1;
            o_insn_done <= !i_slow || insn_cnt == 2'h3;
            o_vec_valid <= 1'b0;
            if (i_vec_rd) begin
                handler <= i_vec_addr + 16'h0100;
                vec_cnt <= i_slow ? 2'h3 : 2'h0;
                o_vec_valid <= !i_slow;
            end else if (vec_cnt != 2'h0) begin
                vec_cnt <= vec_cnt - 2'h1;
                o_vec_valid <= vec_cnt == 2'h1;
            end
        end
    end
endmodule

/* File: test/testbench.sv */
module testbench;
    import iflg_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clk = 1'b0;
    logic i_nrst = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [7:0] wake_n = 8'hFF;
    logic [4:0] req_pin = 5'h00;
    logic conv_start = 1'b0;
    logic xfer_done = 1'b0;
    logic tmr_a = 1'b0;
    logic ser_done = 1'b0;
    logic cap_ovf_en = 1'b0;
    logic [7:0] cap_cnt = 8'h00;
    logic mode16 = 1'b0;
    logic [7:0] cnt_lo = 8'h00;
    logic [7:0] cnt_hi = 8'h00;
    logic [7:0] val_lo = 8'h11;
    logic [7:0] val_hi = 8'h22;
    logic [15:0] ovf_cnt = 16'h0000;
    logic slow = 1'b0;
    logic [7:0] o_rdata, condition_code_register, stack_ccr;
    logic insn_done, vec_valid, irq_pending, stack_push, vec_rd, jump, mask;
    logic [15:0] resume_pc, vec_data, stack_pc, vec_addr, jump_pc;
    int fail_count = 0;
    int n_checks = 0;
    int n_push = 0;
    int cyc = 0;
    int k;
    logic [4:0] vecs [12] = '{5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
        5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h13};
    logic [3:0] clr_a [12] = '{4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h2,
        4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'h1};
    logic [7:0] clr_d [12] = '{8'hFE, 8'hFD, 8'hFB, 8'hF7, 8'hEF, 8'hFE,
        8'h7F, 8'hEF, 8'hFB, 8'hF7, 8'hFE, 8'hBF};

    iflg_ctrl #(.PC_W(16)) dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_wakeup_pin_n(wake_n), .i_req_pin(req_pin), .i_capture_input_pin(1'b0),
        .i_timer_a_ovf(tmr_a), .i_serial_done(ser_done), .i_xfer_done(xfer_done),
        .i_conv_start_flag(conv_start), .i_capture_pin_en(1'b0), .i_capture_rise(1'b0),
        .i_capture_ovf_en(cap_ovf_en), .i_capture_counter(cap_cnt),
        .i_cmp_16bit_mode(mode16), .i_compare_counter_low(cnt_lo),
        .i_compare_counter_high(cnt_hi), .i_compare_value_low(val_lo),
        .i_compare_value_high(val_hi), .i_ovf_counter(ovf_cnt),
        .i_insn_done(insn_done), .i_next_pc(resume_pc), .i_ccr(condition_code_register),
        .i_vec_valid(vec_valid), .i_vec_data(vec_data), .o_irq_pending(irq_pending),
        .o_stack_push(stack_push), .o_stack_pc(stack_pc), .o_stack_ccr(stack_ccr),
        .o_vec_rd(vec_rd), .o_vec_addr(vec_addr), .o_jump(jump), .o_jump_pc(jump_pc),
        .o_mask(mask));

    iflg_cpu_model u_cpu (.i_clk(i_clk), .i_nrst(i_nrst), .i_slow(slow),
        .i_vec_rd(vec_rd), .i_vec_addr(vec_addr), .o_insn_done(insn_done),
        .o_next_pc(resume_pc), .o_ccr(condition_code_register), .o_vec_valid(vec_valid),
        .o_vec_data(vec_data));

    always #12.5 i_clk = ~i_clk;

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk({8'h00, o_rdata}, {8'h00, e});
    endtask

    // hang guard, sized well above the whole sequence
    always @(posedge i_clk) begin
        cyc++;
        if (stack_push === 1'b1) n_push++;
        if (cyc == 20000) begin
            fail_count++;
            final_report();
        end
    end

    // ************************************************************
    // tests
    // ************************************************************
    initial begin
        tick(3);
        i_nrst <= 1'b1;
        tick(4);
        rd(OFS_REQ_ONE, RST_REQ_ONE);
        rd(OFS_REQ_TWO, RST_REQ_TWO);
        rd(OFS_WAKE_FLAGS, RST_ZERO);
        rd(OFS_EN_TWO, RST_EN_TWO);
        rd(OFS_MASK, 8'h01);
        wr(4'hF, 8'hFF);
        rd(4'hF, 8'h00);
        $display("test reset_map done");
        tick(1);
        conv_start <= 1'b1;
        xfer_done <= 1'b1;
        ovf_cnt <= OVF_TOP;
        cap_ovf_en <= 1'b1;
        cap_cnt <= CAP_TOP;
        val_lo <= 8'h55;
        val_hi <= 8'hAA;
        tick(1);
        conv_start <= 1'b0;
        xfer_done <= 1'b0;
        ovf_cnt <= OVF_BOTTOM;
        cap_cnt <= CAP_BOTTOM;
        rd(OFS_REQ_TWO, 8'hD3);
        tick(1);
        mode16 <= 1'b1;
        cnt_lo <= 8'h55;
        cnt_hi <= 8'hAA;
        tick(1);
        cnt_lo <= 8'h00;
        cnt_hi <= 8'h00;
        rd(OFS_REQ_TWO, 8'hDB);
        tick(1);
        mode16 <= 1'b0;
        tick(1);
        cnt_lo <= 8'h55;
        tick(1);
        cnt_lo <= 8'h00;
        rd(OFS_REQ_TWO, 8'hDF);
        wr(OFS_REQ_TWO, 8'hFF);
        rd(OFS_REQ_TWO, 8'hDF);
        wr(OFS_REQ_TWO, 8'hFD);
        rd(OFS_REQ_TWO, 8'hDF);
        // clear and set of the transfer flag in one cycle: set must win
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= OFS_REQ_TWO;
        i_wdata <= 8'h7F;
        xfer_done <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
        xfer_done <= 1'b0;
        rd(OFS_REQ_TWO, 8'hDF);
        $display("test peripheral_flags done");
        wr(OFS_WAKE_FUNC, 8'h01);
        wake_n <= 8'h00;
        tick(6);
        wake_n <= 8'hFF;
        rd(OFS_WAKE_FLAGS, 8'h01);
        wr(OFS_REQ_FUNC, 8'h1F);
        wr(OFS_EDGE_SEL, 8'h05);
        req_pin <= 5'h1F;
        tick(6);
        rd(OFS_REQ_ONE, 8'h25);
        tick(1);
        req_pin <= 5'h00;
        tick(6);
        rd(OFS_REQ_ONE, 8'h3F);
        tick(1);
        tmr_a <= 1'b1;
        tick(1);
        tmr_a <= 1'b0;
        ser_done <= 1'b1;
        tick(1);
        ser_done <= 1'b0;
        rd(OFS_REQ_ONE, 8'hFF);
        wr(OFS_REQ_ONE, 8'h3F);
        rd(OFS_REQ_ONE, 8'h3F);
        chk({15'h0, irq_pending}, 16'h0000);
        wr(OFS_EN_ONE, 8'h3F);
        wr(OFS_EN_TWO, 8'hFF);
        rd(OFS_EN_TWO, 8'hDF);
        chk({15'h0, irq_pending}, 16'h0001);
        tick(10);
        chk(16'(n_push), 16'h0000);
        $display("test pins_and_enables done");
        // clearing only while masked, one source per pass
        for (int i = 0; i < 12; i++) begin
            slow <= i[0];
            wr(OFS_MASK, 8'h00);
            #1;
            k = 0;
            while (jump !== 1'b1 && k < 40) begin
                @(posedge i_clk);
                #1;
                k++;
            end
            chk({15'h0, jump}, 16'h0001);
            chk(jump_pc, {10'h000, vecs[i], 1'b0} + 16'h0100);
            rd(OFS_LAST_VEC, {3'h0, vecs[i]});
            rd(OFS_MASK, 8'h01);
            if (i == 0) rd(OFS_REQ_ONE, 8'h3F);
            wr(clr_a[i], clr_d[i]);
        end
        chk(16'(n_push), 16'h000C);
        rd(OFS_REQ_ONE, RST_REQ_ONE);
        rd(OFS_REQ_TWO, RST_REQ_TWO);
        rd(OFS_WAKE_FLAGS, RST_ZERO);
        $display("test acceptance done");
        final_report();
    end
endmodule

bind iflg_ctrl iflg_ctrl_monitor #(.PC_W(PC_W)) u_mon (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata), .i_insn_done(i_insn_done),
    .i_next_pc(i_next_pc), .i_ccr(i_ccr), .i_vec_valid(i_vec_valid),
    .i_vec_data(i_vec_data), .o_irq_pending(o_irq_pending), .o_stack_push(o_stack_push),
    .o_stack_pc(o_stack_pc), .o_stack_ccr(o_stack_ccr), .o_vec_rd(o_vec_rd),
    .o_vec_addr(o_vec_addr), .o_jump(o_jump), .o_jump_pc(o_jump_pc), .o_mask(o_mask));
